// File: dv/tb_tws_slave.sv
// Self-checking bench of the two-wire slave port driven by a bus master model.
module tb_tws_slave;
	timeunit 1ns;
	timeprecision 100ps;
	import tws_pkg::*;

	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	logic [2:0]  id      = 3'h0;
	logic        dflag   = 1'b0;
	logic        nv_busy = 1'b0;
	logic        scl_p, sda_p, sda_o, sda_oe, nv_commit, wr_stb, busy, rdir;
	logic [7:0]  ptr, idx, wdata, p;
	logic [8:0]  rx;
	logic [16:0] q[$];
	logic [7:0]  qi[$];
	int          err_total = 0;
	int          checks = 0;
	integer      seed = 44698;
	wire logic   scl = ~scl_p;
	wire logic   sda = ~(sda_p | (sda_oe & ~sda_o));
	wire logic [7:0] rd_data = ptr + idx * 8'h25;

	tws_slave dut (
		.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .bus_id_select_bit0_i(id[0]), .bus_id_select_bit1_i(id[1]),
		.bus_id_select_bit2_i(id[2]), .deferred_nv_commit_flag_i(dflag),
		.nv_busy_i(nv_busy), .nv_commit_o(nv_commit), .reg_ptr_o(ptr), .byte_idx_o(idx),
		.wr_data_o(wdata), .wr_stb_o(wr_stb), .rd_data_i(rd_data), .busy_o(busy),
		.read_dir_o(rdir)
	);

	tws_master_model m (
		.clk_i(clk_i), .sda_i(sda), .scl_pull_o(scl_p), .sda_pull_o(sda_p)
	);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] s);
		checks++;
		if (e !== s) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d, errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Output watcher
	// ------------------------------------------------------------
	always @(negedge clk_i) begin
		if (wr_stb === 1'b1) chk("write", q.pop_front(), {1'b1, ptr, wdata});
		if (wr_stb === 1'b1) chk("write index", {9'h0, qi.pop_front()}, {9'h0, idx});
		if (nv_commit === 1'b1) chk("commit", q.pop_front(), {1'b0, ptr, 8'h00});
		if (sda_oe === 1'b1) chk("pull value", 17'h0, {16'h0, sda_o});
	end

	// ------------------------------------------------------------
	// Bus transactions
	// ------------------------------------------------------------
	task automatic addr(input logic [2:0] a, input logic r, input logic ack);
		m.xfer({DEV_ID, a, r, 1'b1}, rx);
		chk("address ack", {16'h0, ~ack}, {16'h0, rx[0]});
	endtask

	task automatic wbyte(input logic [7:0] d);
		m.xfer({d, 1'b1}, rx);
		chk("data ack", 17'h0, {16'h0, rx[0]});
	endtask

	// Pointer, then n random bytes; the stop is left to the caller.
	task automatic wr(input logic [7:0] pt, input int n);
		logic [7:0] d;
		m.start();
		addr(id, 1'b0, 1'b1);
		if (pt == CMD_COMMIT_NV) q.push_back({1'b0, pt, 8'h00});
		wbyte(pt);
		for (int k = 0; k < n; k++) begin
			d = 8'($random(seed));
			q.push_back({1'b1, pt, d});
			qi.push_back(8'(k));
			if (!dflag || pt == REG_BUS_ID) q.push_back({1'b0, pt, 8'h00});
			wbyte(d);
		end
	endtask

	task automatic fin();
		m.stop();
		repeat (5) @(negedge clk_i);
		chk("busy after stop", 17'h0, {16'h0, busy});
	endtask

	// Master acknowledges every byte but the last.
	task automatic rd(input logic [7:0] pt, input int n);
		m.start();
		addr(id, 1'b1, 1'b1);
		chk("direction", 17'h1, {16'h0, rdir});
		for (int k = 0; k < n; k++) begin
			m.xfer({8'hff, k == n - 1}, rx);
			chk("read byte", {9'h0, pt + 8'(k) * 8'h25}, {9'h0, rx[8:1]});
		end
		repeat (6) @(negedge clk_i);
		chk("released", 17'h0, {16'h0, sda_oe});
		fin();
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		chk("reset", 17'h0, {busy, sda_oe, rdir, nv_commit, wr_stb, ptr, idx[3:0]});
		repeat (3) @(negedge clk_i);
		id = 3'($random(seed));
		p = {2'b01, 6'($random(seed))};
		wr(p, 4);
		chk("busy", 17'h1, {16'h0, busy});
		rd(p, 3);
		for (int b = 0; b < 3; b++) begin
			m.start();
			addr(id ^ (3'h1 << b), 1'b0, 1'b0);
			fin();
		end
		nv_busy = 1'b1;
		m.start();
		addr(id, 1'b0, 1'b0);
		fin();
		nv_busy = 1'b0;
		m.start();
		addr(id, 1'b0, 1'b1);
		fin();
		dflag = 1'b1;
		wr(p, 2);
		fin();
		wr(CMD_COMMIT_NV, 0);
		fin();
		wr(REG_BUS_ID, 1);
		fin();
		dflag = 1'b0;
		for (int r = 0; r < 2; r++) begin
			m.hcyc = r ? 500 : 125;
			wr(p, 1);
			fin();
		end
		chk("steady data", 17'h0, 17'(m.unstable));
		chk("pending notes", 17'h0, 17'(q.size() + qi.size()));
		end_sim();
	end

	initial begin
		#1000000;
		err_total++;
		end_sim();
	end
endmodule // tb_tws_slave

// File: dv/tws_master_model.sv
// Behavioural two-wire bus master that makes every clock pulse and condition.
module tws_master_model (
	// Clock
	input  wire logic clk_i,
	// Bus
	input  wire logic sda_i,
	output logic      scl_pull_o,
	output logic      sda_pull_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int hcyc = 8;
	int unstable = 0;

	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end

	task automatic wq();
		repeat (hcyc / 2) @(negedge clk_i);
	endtask

	task automatic wh();
		repeat (hcyc) @(negedge clk_i);
	endtask

	// ------------------------------------------------------------
	// Conditions
	// ------------------------------------------------------------
	// Lines are only pulled or released, so a released line shows the pull-up.
	task automatic start();
		wq();
		sda_pull_o = 1'b0;
		wq();
		scl_pull_o = 1'b0;
		wh();
		sda_pull_o = 1'b1;
		wh();
		scl_pull_o = 1'b1;
	endtask

	task automatic stop();
		wq();
		sda_pull_o = 1'b1;
		wq();
		scl_pull_o = 1'b0;
		wh();
		sda_pull_o = 1'b0;
		wh();
	endtask

	// Nine slots, most significant first; the ninth carries the acknowledge.
	// Data moves a quarter period after the clock falls so no edge coincides.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		logic s0;
		for (int i = 8; i >= 0; i--) begin
			wq();
			sda_pull_o = ~tx[i];
			wq();
			scl_pull_o = 1'b0;
			@(negedge clk_i);
			s0 = sda_i;
			repeat (hcyc - 1) @(negedge clk_i);
			rx[i] = sda_i;
			if (s0 !== rx[i]) unstable++;
			scl_pull_o = 1'b1;
		end
	endtask
endmodule // tws_master_model

// File: rtl/tws_pin_sync.sv
// Two-stage synchroniser and edge finder for the clock and data lines.
module tws_pin_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Bus pins
	input  wire logic scl_pin_i,
	input  wire logic sda_pin_i,
	// Synchronised levels and edges
	output logic      scl_o,
	output logic      sda_o,
	output logic      scl_rise_o,
	output logic      scl_fall_o,
	output logic      sda_rise_o,
	output logic      sda_fall_o
);
	import tws_pkg::*;

	typedef struct packed {
		logic [2:0] scl;
		logic [2:0] sda;
	} tws_sync_s;

	localparam tws_sync_s SYNC_RESET = '{scl: LINE_IDLE, sda: LINE_IDLE};

	tws_sync_s q_r;
	tws_sync_s q_nxt;

	// ------------------------------------------------------------
	// Shift chain
	// ------------------------------------------------------------
	// Stage 0 is read only by stage 1; edges come from stages 1 and 2.
	always_comb begin
		q_nxt     = q_r;
		q_nxt.scl = {q_r.scl[1:0], scl_pin_i};
		q_nxt.sda = {q_r.sda[1:0], sda_pin_i};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= SYNC_RESET;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign scl_o      = q_r.scl[1];
	assign sda_o      = q_r.sda[1];
	assign scl_rise_o = q_r.scl[1] & ~q_r.scl[2];
	assign scl_fall_o = ~q_r.scl[1] & q_r.scl[2];
	assign sda_rise_o = q_r.sda[1] & ~q_r.sda[2];
	assign sda_fall_o = ~q_r.sda[1] & q_r.sda[2];

endmodule // tws_pin_sync

// File: rtl/tws_pkg.sv
// Shared constants and types of the two-wire slave port.
package tws_pkg;

	// ------------------------------------------------------------
	// Byte framing
	// ------------------------------------------------------------
	localparam int         BYTE_BITS    = 8;
	localparam int         MSB_POS      = BYTE_BITS - 1;
	localparam int         RW_POS       = 0;
	localparam logic       RW_READ      = 1'b1;
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
	localparam logic [3:0] BIT_CNT_ONE  = 4'h1;
	localparam logic [3:0] BIT_CNT_LAST = 4'h7;
	localparam logic [3:0] BIT_CNT_FULL = 4'h8;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [7:0] BYTE_ONE     = 8'h01;

	// ------------------------------------------------------------
	// Addressing and commands
	// ------------------------------------------------------------
	// Fixed device identifier in the upper nibble; the value is arbitrary.
	localparam logic [3:0] DEV_ID        = 4'h5;
	// Pointer code of the commit-to-nonvolatile command.
	localparam logic [7:0] CMD_COMMIT_NV = 8'hc3;
	// Pointer of the bus-identity settings register.
	localparam logic [7:0] REG_BUS_ID    = 8'h20;

	// ------------------------------------------------------------
	// Line levels
	// ------------------------------------------------------------
	localparam logic [2:0] LINE_IDLE = 3'h7;
	localparam logic       PULL_LOW  = 1'b0;

	// ------------------------------------------------------------
	// Protocol states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_RX,
		ST_ACK_RX,
		ST_TX,
		ST_ACK_TX
	} tws_state_e;

endpackage

// File: rtl/tws_slave.sv
// Two-wire serial slave port: conditions, addressing, byte transfer and acknowledge.
//
// Overview of operation
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop condition ending the transfer.
// - Data changes only while clock low; one clock pulse per bit.
// - Bytes are eight bits; the receiver acknowledges in a ninth slot.
// - No limit on bytes between start and stop.
// - Works at both 100kHz and 400kHz bus clock.
// - Acknowledge holds data low through the whole ninth clock high phase.
// - While nonvolatile write is busy, every request gets a not-acknowledge.
// - After the master's final not-acknowledge, the slave releases the data line.
// - Writes: address byte, then data bytes, each acknowledged by the slave.
// - Reads: slave acknowledges address, sends bytes; master refuses the last.
// - Repeated start ends one transfer and begins the next at once.
// - Address is compared in hardware after the first byte; direction is only stored.
// - Read direction makes the slave transmit on data, clock still from master.
// - First byte holds fixed identifier, programmable address bits, and direction.
// - Lines are open-drain; the slave only pulls data low or releases.
// - Three bus-identity bits set the address; changes commit to nonvolatile at once.
// - The commit command copies working registers to nonvolatile memory.
module tws_slave (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Bus pins, open-drain
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Address and nonvolatile control
	input  wire logic       bus_id_select_bit0_i,
	input  wire logic       bus_id_select_bit1_i,
	input  wire logic       bus_id_select_bit2_i,
	input  wire logic       deferred_nv_commit_flag_i,
	input  wire logic       nv_busy_i,
	output logic            nv_commit_o,
	// Register side
	output logic [7:0]      reg_ptr_o,
	output logic [7:0]      byte_idx_o,
	output logic [7:0]      wr_data_o,
	output logic            wr_stb_o,
	input  wire logic [7:0] rd_data_i,
	// Status
	output logic            busy_o,
	output logic            read_dir_o
);
	import tws_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		tws_pkg::tws_state_e st;
		logic [7:0]          shreg;
		logic [3:0]          bitcnt;
		logic                rw;
		logic                have_ptr;
		logic [7:0]          ptr;
		logic [7:0]          idx;
		logic                drive;
		logic                mst_ack;
		logic [7:0]          wr_data;
		logic                wr_stb;
		logic                commit;
	} tws_slave_s;

	localparam tws_slave_s SLAVE_RESET = '{
		st:       ST_IDLE,
		shreg:    BYTE_ZERO,
		bitcnt:   BIT_CNT_ZERO,
		rw:       1'b0,
		have_ptr: 1'b0,
		ptr:      BYTE_ZERO,
		idx:      BYTE_ZERO,
		drive:    1'b0,
		mst_ack:  1'b0,
		wr_data:  BYTE_ZERO,
		wr_stb:   1'b0,
		commit:   1'b0
	};

	tws_slave_s q_r;
	tws_slave_s q_nxt;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic sda_fall;
	logic start_cond;
	logic stop_cond;
	logic addr_match;

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	// At 100 MHz sampling, a 400kHz clock high phase spans over a
	// hundred cycles, so edges are seen well apart in both modes.
	tws_pin_sync u_sync (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.scl_pin_i  (scl_i),
		.sda_pin_i  (sda_i),
		.scl_o      (scl_s),
		.sda_o      (sda_s),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.sda_rise_o (sda_rise),
		.sda_fall_o (sda_fall)
	);

	// ------------------------------------------------------------
	// Bus conditions and address decode
	// ------------------------------------------------------------
	assign start_cond = scl_s & sda_fall;
	assign stop_cond  = scl_s & sda_rise;

	// Identifier and selected address bits; the direction bit is left out.
	assign addr_match = (q_r.shreg[7:4] == DEV_ID) &&
	                    (q_r.shreg[3:1] == {bus_id_select_bit2_i,
	                                        bus_id_select_bit1_i,
	                                        bus_id_select_bit0_i});

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	// Sampling on clock rise and driving on clock fall keeps the line
	// steady through each high phase; the synchroniser delay adds hold.
	always_comb begin
		q_nxt        = q_r;
		q_nxt.wr_stb = 1'b0;
		q_nxt.commit = 1'b0;
		// In a write the index moves on only after the strobe, so each byte is stored
		// at its own position and the first one lands on index zero.
		if (q_r.wr_stb) begin
			q_nxt.idx = q_r.idx + BYTE_ONE;
		end
		if (start_cond) begin
			// A repeated start keeps the pointer for a following read.
			q_nxt.st       = ST_ADDR;
			q_nxt.bitcnt   = BIT_CNT_ZERO;
			q_nxt.have_ptr = 1'b0;
			q_nxt.idx      = BYTE_ZERO;
			q_nxt.drive    = 1'b0;
		end else if (stop_cond) begin
			q_nxt.st    = ST_IDLE;
			q_nxt.drive = 1'b0;
		end else begin
			unique case (q_r.st)
				ST_IDLE: begin
					q_nxt.drive = 1'b0;
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						// Bits arrive most significant first.
						q_nxt.shreg  = {q_r.shreg[6:0], sda_s};
						q_nxt.bitcnt = q_r.bitcnt + BIT_CNT_ONE;
					end else if (scl_fall && q_r.bitcnt == BIT_CNT_FULL) begin
						q_nxt.bitcnt = BIT_CNT_ZERO;
						if (q_r.st == ST_ADDR) begin
							if (addr_match && !nv_busy_i) begin
								q_nxt.drive = 1'b1;
								q_nxt.rw    = q_r.shreg[RW_POS];
								q_nxt.st    = ST_ACK_ADDR;
							end else begin
								// Leaving the line released is the refusal.
								q_nxt.st = ST_IDLE;
							end
						end else begin
							q_nxt.drive = 1'b1;
							q_nxt.st    = ST_ACK_RX;
							if (!q_r.have_ptr) begin
								q_nxt.ptr      = q_r.shreg;
								q_nxt.have_ptr = 1'b1;
								q_nxt.idx      = BYTE_ZERO;
								q_nxt.commit   = (q_r.shreg == CMD_COMMIT_NV);
							end else begin
								// The index only wraps; byte count is open.
								q_nxt.wr_data = q_r.shreg;
								q_nxt.wr_stb  = 1'b1;
								q_nxt.commit  = !deferred_nv_commit_flag_i ||
								                (q_r.ptr == REG_BUS_ID);
							end
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						q_nxt.bitcnt = BIT_CNT_ZERO;
						if (q_r.rw == RW_READ) begin
							// Turn round and place the first bit at once.
							q_nxt.st    = ST_TX;
							q_nxt.shreg = rd_data_i;
							q_nxt.drive = !rd_data_i[MSB_POS];
						end else begin
							q_nxt.st    = ST_RX;
							q_nxt.drive = 1'b0;
						end
					end
				end
				ST_ACK_RX: begin
					if (scl_fall) begin
						q_nxt.st    = ST_RX;
						q_nxt.drive = 1'b0;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (q_r.bitcnt == BIT_CNT_LAST) begin
							// Free the line for the master's answer.
							q_nxt.st     = ST_ACK_TX;
							q_nxt.drive  = 1'b0;
							q_nxt.bitcnt = BIT_CNT_ZERO;
						end else begin
							q_nxt.shreg  = {q_r.shreg[6:0], 1'b0};
							q_nxt.drive  = !q_r.shreg[MSB_POS - 1];
							q_nxt.bitcnt = q_r.bitcnt + BIT_CNT_ONE;
						end
					end
				end
				ST_ACK_TX: begin
					if (scl_rise) begin
						q_nxt.mst_ack = !sda_s;
						if (!sda_s) begin
							q_nxt.idx = q_r.idx + BYTE_ONE;
						end
					end else if (scl_fall) begin
						if (q_r.mst_ack) begin
							q_nxt.st    = ST_TX;
							q_nxt.shreg = rd_data_i;
							q_nxt.drive = !rd_data_i[MSB_POS];
						end else begin
							q_nxt.st    = ST_IDLE;
							q_nxt.drive = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= SLAVE_RESET;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// The clock line has no driver here, and data is only ever pulled low.
	assign sda_o       = PULL_LOW;
	assign sda_oe_o    = q_r.drive;
	assign nv_commit_o = q_r.commit;
	assign reg_ptr_o   = q_r.ptr;
	assign byte_idx_o  = q_r.idx;
	assign wr_data_o   = q_r.wr_data;
	assign wr_stb_o    = q_r.wr_stb;
	assign busy_o      = (q_r.st != ST_IDLE);
	assign read_dir_o  = q_r.rw;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence seq_addr_end;
		q_r.st == ST_ADDR && scl_fall && q_r.bitcnt == BIT_CNT_FULL;
	endsequence

	sequence seq_rx_end;
		q_r.st == ST_RX && scl_fall && q_r.bitcnt == BIT_CNT_FULL;
	endsequence

	sequence seq_ack_hold;
		sda_oe_o && !scl_fall;
	endsequence

	chk_only_pull_low:
		assert property (sda_o == PULL_LOW && (!sda_oe_o ||
		                 q_r.st inside {ST_ACK_ADDR, ST_ACK_RX, ST_TX}))
		else $error("Data line driven high or pulled outside a drive slot.");

	chk_start_seen:
		assert property (start_cond |=> q_r.st == ST_ADDR && !sda_oe_o &&
		                 q_r.bitcnt == BIT_CNT_ZERO)
		else $error("Start condition not taken.");

	chk_stop_seen:
		assert property (stop_cond && !start_cond |=> q_r.st == ST_IDLE && !sda_oe_o)
		else $error("Stop condition not taken.");

	chk_steady_high:
		assert property (scl_s && $past(scl_s) && !$past(start_cond) &&
		                 !$past(stop_cond) |-> $stable(sda_oe_o))
		else $error("Data drive changed while clock high.");

	chk_busy_refuse:
		assert property (seq_addr_end and nv_busy_i |=> !sda_oe_o && q_r.st == ST_IDLE)
		else $error("Request acknowledged during nonvolatile write.");

	chk_addr_ack:
		assert property (seq_addr_end and (addr_match && !nv_busy_i) |=>
		                 sda_oe_o && q_r.st == ST_ACK_ADDR)
		else $error("Matching address not acknowledged.");

	chk_addr_miss:
		assert property (seq_addr_end and !addr_match |=> !sda_oe_o ##1 !sda_oe_o)
		else $error("Foreign address acknowledged.");

	chk_rx_ack:
		assert property (seq_rx_end |=> seq_ack_hold ##1 (sda_oe_o || scl_fall))
		else $error("Received byte not acknowledged.");

	chk_ptr_then_data:
		assert property (seq_rx_end and q_r.have_ptr |=>
		                 wr_stb_o && wr_data_o == $past(q_r.shreg) &&
		                 byte_idx_o == $past(q_r.idx) ##1 !wr_stb_o)
		else $error("Data byte not delivered.");

	chk_read_turn:
		assert property (q_r.st == ST_ACK_ADDR && scl_fall && q_r.rw |=>
		                 q_r.st == ST_TX && sda_oe_o == !$past(rd_data_i[MSB_POS]))
		else $error("Read direction did not start transmit.");

	chk_nak_release:
		assert property (q_r.st == ST_ACK_TX && scl_fall && !q_r.mst_ack &&
		                 !start_cond && !stop_cond |=> !sda_oe_o && q_r.st == ST_IDLE)
		else $error("Line held after final not-acknowledge.");

	chk_commit_cmd:
		assert property (seq_rx_end and (!q_r.have_ptr && q_r.shreg == CMD_COMMIT_NV) |=>
		                 nv_commit_o ##1 !nv_commit_o)
		else $error("Commit command not passed on.");

endmodule // tws_slave
